// ---- hdl/mcu_reset_and_power_modes.sv ----
`timescale 1ns/10ps
// Contract
// - after any reset, core restarts fetching at address zero
// - latch-enable and store strobe driven high throughout reset
// - warm reset leaves data RAM untouched; power-up contents undefined
// - every special function register loads its reset value on reset
// - power-up init writes ones to every port pin once oscillator runs
// - power guard blocks flash programming while supply is invalid
// - idle gates core clock only; peripherals and interrupts keep clocking
// - latch-enable and store strobe stay high during idle
// - enabled interrupt ends idle, clears idle bit, resumes after return
// - reset out of idle allows two more core cycles before reset
// - power down stops all clocks, keeps state, drives strobes low
// - power down ends only on external interrupt or hardware reset
// - standby keeps full state and resumes on next clock
// - any interrupt exit from a low-power mode resumes after the instruction that entered it
// - watchdog counter frozen in idle, resumes on interrupt exit
module mcu_reset_and_power_modes #(
	parameter int unsigned PORT_COUNT = 4
) (
	input  wire logic                    clk,
	input  wire logic                    reset,
	input  wire logic                    rstPin,
	input  wire logic                    oscStable,
	input  wire logic                    supplyValid,
	input  wire logic                    pwrCtrlWrite,
	input  wire logic [7:0]              pwrCtrlData,
	input  wire logic                    intPending,
	input  wire logic                    extIntPending,
	input  wire logic                    intServiceStart,
	input  wire logic                    flashProgReq,
	output logic                         coreClkEn,
	output logic                         periphClkEn,
	output logic                         intClkEn,
	output logic                         watchdogRun,
	output logic                         coreReset,
	output logic                         sfrReset,
	output logic                         ramClear,
	output logic [15:0]                  fetchVector,
	output logic                         addrLatchOut,
	output logic                         addrLatchOe,
	output logic                         addrLatchWeakPull,
	output logic                         program_store_strobe_n,
	output logic                         programStoreOe,
	output logic                         programStoreWeakPull,
	output logic [8*PORT_COUNT-1:0]      portInitData,
	output logic                         portInitWrite,
	output logic                         flashProgAllow,
	output logic [7:0]                   power_control_register
);
	mrp_rst_if rif ();
	assign rif.rstPin    = rstPin;
	assign rif.oscStable = oscStable;

	mrp_rst_filter uFilter (
		.clk   (clk),
		.reset (reset),
		.rif   (rif)
	);

	mrp_pkg::mrp_state_e state_q;
	mrp_pkg::mrp_state_e state_d;
	logic [7:0]          pctl_q;
	logic [7:0]          pctl_d;
	logic [2:0]          cnt_q;
	logic [2:0]          cnt_d;
	logic                coreEn_q, coreEn_d;
	logic                perEn_q, perEn_d;
	logic                wdRun_q, wdRun_d;
	logic                coreRst_q, coreRst_d;
	logic                sfrRst_q, sfrRst_d;
	logic                strobeHi_q, strobeHi_d;
	logic                portWr_q, portWr_d;
	logic                flashOk_q, flashOk_d;
	logic                warm_q, warm_d;

	function automatic logic isIdleReq(input logic [7:0] v);
		return v[mrp_pkg::PWR_IDLE_BIT] && !v[mrp_pkg::PWR_DOWN_BIT];
	endfunction

	function automatic logic isDownReq(input logic [7:0] v);
		return v[mrp_pkg::PWR_DOWN_BIT];
	endfunction

	always_comb begin
		state_d    = state_q;
		pctl_d     = pctl_q;
		cnt_d      = cnt_q;
		warm_d     = warm_q;
		if (pwrCtrlWrite && state_q == mrp_pkg::ST_RUN) begin
			pctl_d = pwrCtrlData;
		end
		case (state_q)
			mrp_pkg::ST_POWERUP: begin
				if (oscStable) begin
					state_d = mrp_pkg::ST_RESET;
				end
			end
			mrp_pkg::ST_RESET: begin
				pctl_d = mrp_pkg::PWR_CTRL_RESET;
				cnt_d  = '0;
				if (!rif.rstQualified && !rstPin) begin
					state_d = mrp_pkg::ST_INIT;
				end
			end
			mrp_pkg::ST_INIT: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == 3'(mrp_pkg::INIT_CYCLES - 1)) begin
					state_d = mrp_pkg::ST_RUN;
					warm_d  = 1'b1;
				end
			end
			mrp_pkg::ST_RUN: begin
				if (isDownReq(pctl_d)) begin
					state_d = mrp_pkg::ST_PDOWN;
				end else if (isIdleReq(pctl_d)) begin
					state_d = mrp_pkg::ST_IDLE;
				end
			end
			mrp_pkg::ST_IDLE: begin
				if (rif.rstQualified) begin
					state_d = mrp_pkg::ST_SLIP;
					cnt_d   = '0;
				end else if (intPending || intServiceStart) begin
					state_d = mrp_pkg::ST_RUN;
					pctl_d[mrp_pkg::PWR_IDLE_BIT] = 1'b0;
				end
			end
			mrp_pkg::ST_PDOWN: begin
				if (rif.rstQualified) begin
					state_d = mrp_pkg::ST_RESET;
				end else if (extIntPending) begin
					state_d = mrp_pkg::ST_RUN;
					pctl_d[mrp_pkg::PWR_DOWN_BIT] = 1'b0;
					// a combined request was power down alone, so idle must not follow
					pctl_d[mrp_pkg::PWR_IDLE_BIT] = 1'b0;
				end
			end
			mrp_pkg::ST_SLIP: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == 3'(mrp_pkg::IDLE_EXIT_SLIP - 1)) begin
					state_d = mrp_pkg::ST_RESET;
				end
			end
			default: begin
				state_d = mrp_pkg::ST_POWERUP;
			end
		endcase
		if (rif.rstQualified && state_q != mrp_pkg::ST_IDLE && state_q != mrp_pkg::ST_SLIP
				&& state_q != mrp_pkg::ST_POWERUP) begin
			state_d = mrp_pkg::ST_RESET;
		end
	end

	// outputs registered from the next state so they track it with no lag
	always_comb begin
		coreEn_d   = (state_d == mrp_pkg::ST_RUN) || (state_d == mrp_pkg::ST_SLIP);
		perEn_d    = (state_d != mrp_pkg::ST_PDOWN) && (state_d != mrp_pkg::ST_POWERUP);
		wdRun_d    = (state_d == mrp_pkg::ST_RUN);
		coreRst_d  = (state_d == mrp_pkg::ST_RESET) || (state_d == mrp_pkg::ST_INIT)
			|| (state_d == mrp_pkg::ST_POWERUP);
		sfrRst_d   = (state_d == mrp_pkg::ST_RESET) || (state_d == mrp_pkg::ST_POWERUP);
		strobeHi_d = (state_d != mrp_pkg::ST_PDOWN);
		portWr_d   = (state_d == mrp_pkg::ST_INIT) && !warm_q;
		flashOk_d  = supplyValid && flashProgReq && (state_d == mrp_pkg::ST_RUN);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q    <= mrp_pkg::ST_POWERUP;
			pctl_q     <= mrp_pkg::PWR_CTRL_RESET;
			cnt_q      <= '0;
			warm_q     <= 1'b0;
			coreEn_q   <= 1'b0;
			perEn_q    <= 1'b0;
			wdRun_q    <= 1'b0;
			coreRst_q  <= 1'b1;
			sfrRst_q   <= 1'b1;
			strobeHi_q <= 1'b1;
			portWr_q   <= 1'b0;
			flashOk_q  <= 1'b0;
		end else begin
			state_q    <= state_d;
			pctl_q     <= pctl_d;
			cnt_q      <= cnt_d;
			warm_q     <= warm_d;
			coreEn_q   <= coreEn_d;
			perEn_q    <= perEn_d;
			wdRun_q    <= wdRun_d;
			coreRst_q  <= coreRst_d;
			sfrRst_q   <= sfrRst_d;
			strobeHi_q <= strobeHi_d;
			portWr_q   <= portWr_d;
			flashOk_q  <= flashOk_d;
		end
	end

	// standby needs no logic: a stopped input clock freezes every flop
	assign coreClkEn              = coreEn_q;
	assign periphClkEn            = perEn_q;
	assign intClkEn               = perEn_q;
	assign watchdogRun            = wdRun_q;
	assign coreReset              = coreRst_q;
	assign sfrReset               = sfrRst_q;
	assign ramClear               = 1'b0;
	assign fetchVector            = mrp_pkg::RESET_VECTOR;
	assign addrLatchOut           = strobeHi_q;
	assign addrLatchOe            = 1'b1;
	assign addrLatchWeakPull      = coreRst_q;
	assign program_store_strobe_n = strobeHi_q;
	assign programStoreOe         = 1'b1;
	assign programStoreWeakPull   = coreRst_q;
	assign portInitData           = {PORT_COUNT{mrp_pkg::PORT_RESET}};
	assign portInitWrite          = portWr_q;
	assign flashProgAllow         = flashOk_q;
	assign power_control_register = pctl_q;
endmodule // mcu_reset_and_power_modes

// ---- hdl/mrp_pkg.sv ----
package mrp_pkg;
	localparam int unsigned CLK_HZ         = 40000000;
	localparam int unsigned RESET_CLOCKS   = 24;
	localparam int unsigned IDLE_EXIT_SLIP = 2;
	localparam logic [15:0] RESET_VECTOR   = 16'h0000;
	localparam int unsigned PWR_IDLE_BIT   = 0;
	localparam int unsigned PWR_DOWN_BIT   = 1;
	localparam logic [7:0]  PWR_CTRL_RESET = 8'h00;
	localparam logic [7:0]  PORT_RESET     = 8'hff;
	localparam int unsigned RST_CNT_W      = 5;
	localparam int unsigned INIT_CYCLES    = 4;

	typedef enum logic [2:0] {
		ST_POWERUP = 3'b000,
		ST_RESET   = 3'b001,
		ST_INIT    = 3'b010,
		ST_RUN     = 3'b011,
		ST_IDLE    = 3'b100,
		ST_PDOWN   = 3'b101,
		ST_SLIP    = 3'b110
	} mrp_state_e;
endpackage

// ---- hdl/mrp_rst_if.sv ----
`timescale 1ns/10ps
interface mrp_rst_if;
	logic rstPin;
	logic oscStable;
	logic rstQualified;
	modport filt (input rstPin, input oscStable, output rstQualified);
	modport seq  (input rstQualified);
endinterface

// ---- hdl/mrp_rst_filter.sv ----
`timescale 1ns/10ps
module mrp_rst_filter (
	input  wire logic clk,
	input  wire logic reset,
	mrp_rst_if.filt   rif
);
	logic [mrp_pkg::RST_CNT_W-1:0] cnt_q;
	logic [mrp_pkg::RST_CNT_W-1:0] cnt_d;
	logic                          qual_q;
	logic                          qual_d;

	// shorter pulses are ignored so a glitch cannot restart the core
	always_comb begin
		cnt_d  = cnt_q;
		qual_d = 1'b0;
		if (!rif.rstPin || !rif.oscStable) begin
			cnt_d = '0;
		end else if (cnt_q != mrp_pkg::RST_CNT_W'(mrp_pkg::RESET_CLOCKS)) begin
			cnt_d = cnt_q + 1'b1;
		end
		if (rif.rstPin && cnt_d == mrp_pkg::RST_CNT_W'(mrp_pkg::RESET_CLOCKS)) begin
			qual_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_q  <= '0;
			qual_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			qual_q <= qual_d;
		end
	end

	assign rif.rstQualified = qual_q;
endmodule // mrp_rst_filter

// ---- verif/mrp_ext_model.sv ----
`timescale 1ns/10ps
module mrp_ext_model (
	input  wire logic       clk,
	input  wire logic       pulseGo,
	input  wire logic [7:0] pulseLen,
	output logic            rstPin,
	output logic            oscStable
);
	int cnt = 0;
	int hold = 0;
	initial begin
		rstPin = 1'b1;
		oscStable = 1'b0;
	end
	// pin held well past the minimum so power-up never depends on the filter edge
	always @(posedge clk) begin
		if (pulseGo) hold = pulseLen;
		#2;
		cnt++;
		if (cnt == 6) oscStable = 1'b1;
		rstPin = (cnt < 46) || (hold > 0);
		if (hold > 0) hold--;
	end
endmodule // mrp_ext_model

// ---- verif/mrp_checker.sv ----
`timescale 1ns/10ps
module mrp_checker (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       rstPin,
	input wire logic       oscStable,
	input wire logic       supplyValid,
	input wire logic       pwrCtrlWrite,
	input wire logic [7:0] pwrCtrlData,
	input wire logic       intPending,
	input wire logic       extIntPending,
	input wire logic       coreClkEn,
	input wire logic       periphClkEn,
	input wire logic       watchdogRun,
	input wire logic       coreReset,
	input wire logic       addrLatchOut,
	input wire logic       program_store_strobe_n,
	input wire logic       addrLatchWeakPull,
	input wire logic       portInitWrite,
	input wire logic       flashProgAllow,
	input wire logic [7:0] power_control_register
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic [4:0] hiCnt_q, hiCnt_d;
	wire idle_request_bit = !coreClkEn && periphClkEn && !coreReset;
	wire pdn = !periphClkEn && !addrLatchOut;
	wire wr  = watchdogRun && pwrCtrlWrite;
	// saturates so a long pin hold cannot wrap back to a small count
	always_comb hiCnt_d = (rstPin && oscStable) ? hiCnt_q + {4'h0, hiCnt_q != 5'h1f} : 5'h00;
	always_ff @(posedge clk) hiCnt_q <= reset ? 5'h00 : hiCnt_d;
	// a pin sampled low last edge means no qualified reset can overrule the step checked
	idle_entry_a:
		assert property (wr && pwrCtrlData[1:0] == 2'b01 && !$past(rstPin)
			|=> idle_request_bit && !watchdogRun && addrLatchOut && program_store_strobe_n)
			else $error("idle entry wrong");
	pdown_entry_a:
		assert property (wr && pwrCtrlData[1] && !$past(rstPin)
			|=> pdn && !coreClkEn && !watchdogRun)
			else $error("power down entry wrong");
	reset_strobe_a:
		assert property (coreReset |-> addrLatchOut && program_store_strobe_n && addrLatchWeakPull)
			else $error("strobes not high in reset");
	idle_wake_a:
		assert property (idle_request_bit && intPending && !$past(rstPin)
			|=> coreClkEn && !power_control_register[0])
			else $error("idle not left on interrupt");
	pd_wake_a:
		assert property (pdn && extIntPending && !$past(rstPin) |=> watchdogRun)
			else $error("power down not left");
	pd_hold_a:
		assert property (pdn && !extIntPending && !rstPin && !$past(rstPin) |=> pdn)
			else $error("power down left early");
	flash_guard_a:
		assert property (!supplyValid |=> !flashProgAllow) else $error("flash allowed on bad supply");
	init_ones_a:
		assert property (portInitWrite |-> coreReset) else $error("port init outside reset");
	// the filter qualifies one edge before the run state drops, so look one edge back
	reset_filter_a:
		assert property ($fell(watchdogRun) && coreReset
			|-> $past(hiCnt_q) >= 5'(mrp_pkg::RESET_CLOCKS))
			else $error("reset taken on short pulse");
	cover property (wr && pwrCtrlData[1:0] == 2'b01);
	cover property (wr && pwrCtrlData[1]);
	cover property (pdn && extIntPending);
	cover property ($fell(watchdogRun) && coreReset);
endmodule // mrp_checker
bind mcu_reset_and_power_modes mrp_checker mrp_checker_inst (.clk, .reset, .rstPin, .oscStable,
	.supplyValid, .pwrCtrlWrite, .pwrCtrlData, .intPending, .extIntPending, .coreClkEn,
	.periphClkEn, .watchdogRun, .coreReset, .addrLatchOut, .program_store_strobe_n,
	.addrLatchWeakPull, .portInitWrite, .flashProgAllow, .power_control_register);

// ---- verif/mcu_reset_and_power_modes_test.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module mcu_reset_and_power_modes_test;
	logic        clk = 0, reset = 1, clkGate = 1, supplyValid = 1, pwrCtrlWrite = 0;
	logic        intPending = 0, extIntPending = 0, intServiceStart = 0, flashProgReq = 0;
	logic        pulseGo = 0, rstPin, oscStable, coreClkEn, periphClkEn, watchdogRun;
	logic        coreReset, addrLatchOut, psn, portInitWrite, flashProgAllow, ramClear, initSeen;
	logic        intClkEn, sfrReset, alOe, psOe, alWp, psWp;
	logic [7:0]  pwrCtrlData = 8'h00, pulseLen = 8'h00, pcr;
	logic [15:0] lfsr = 16'h458d, fetchVector;
	logic [31:0] portInitData;
	logic [3:0]  slip;
	int          n_mismatch = 0, check_count = 0;
	initial forever #12.5 if (clkGate) clk = ~clk;
	mrp_ext_model mrp_ext_model_inst (.clk, .pulseGo, .pulseLen, .rstPin, .oscStable);
	mcu_reset_and_power_modes mcu_reset_and_power_modes_inst (.clk, .reset, .rstPin, .oscStable,
		.supplyValid, .pwrCtrlWrite, .pwrCtrlData, .intPending, .extIntPending, .intServiceStart,
		.flashProgReq, .coreClkEn, .periphClkEn, .intClkEn, .watchdogRun, .coreReset,
		.sfrReset, .ramClear, .fetchVector, .addrLatchOut, .addrLatchOe(alOe),
		.addrLatchWeakPull(alWp), .program_store_strobe_n(psn), .programStoreOe(psOe),
		.programStoreWeakPull(psWp), .portInitData, .portInitWrite, .flashProgAllow,
		.power_control_register(pcr));
	always @(posedge clk) if (portInitWrite === 1'b1) begin
		initSeen <= 1'b1;
		`CHK("portData", 32'hffffffff, portInitData)
	end
	function automatic logic [15:0] nextRnd(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic waitRun;
		int i;
		for (i = 0; i < 200 && watchdogRun !== 1'b1; i++) step(1);
		if (i == 200) begin n_mismatch++; $display("[ERR] run wait timeout"); final_report; end
	endtask
	// upper data bits are random so only the two mode bits may steer the mode
	task automatic wrPwr(input logic [1:0] m);
		lfsr = nextRnd(lfsr);
		pwrCtrlData = {lfsr[7:2], m};
		pwrCtrlWrite = 1'b1;
		step(1);
		pwrCtrlWrite = 1'b0;
	endtask
	task automatic afterReset;
		waitRun;
		`CHK("vector", mrp_pkg::RESET_VECTOR, fetchVector)
		`CHK("pwrReg", mrp_pkg::PWR_CTRL_RESET, pcr)
		`CHK("ramClear", 1'b0, ramClear)
		`CHK("runPins", 3'h0, {sfrReset, alWp, psWp})
	endtask
	initial begin
		initSeen = 1'b0;
		step(12);
		reset = 1'b0;
		afterReset;
		`CHK("coldInit", 1'b1, initSeen)
		$display("cold start done");
		for (int i = 0; i < 2; i++) begin
			wrPwr(2'b01);
			`CHK("idleClk", 2'b01, {coreClkEn, periphClkEn})
			`CHK("idleIntClk", 1'b1, intClkEn)
			`CHK("idleStrobe", 2'b11, {psn, addrLatchOut})
			`CHK("idleWdog", 1'b0, watchdogRun)
			step(2 + lfsr[3:0]);
			if (i == 0) intPending = 1'b1; else intServiceStart = 1'b1;
			step(1);
			intPending = 1'b0;
			intServiceStart = 1'b0;
			`CHK("wake", 3'b110, {coreClkEn, watchdogRun, pcr[0]})
		end
		$display("idle done");
		for (int m = 2; m < 4; m++) begin
			wrPwr(m[1:0]);
			`CHK("pdOut", 4'h0, {periphClkEn, coreClkEn, psn, addrLatchOut})
			`CHK("pdIntClk", 1'b0, intClkEn)
			intPending = 1'b1;
			step(4);
			`CHK("pdHold", 1'b0, periphClkEn)
			intPending = 1'b0;
			extIntPending = 1'b1;
			step(1);
			extIntPending = 1'b0;
			`CHK("pdWake", 1'b1, watchdogRun)
			`CHK("pdBits", 2'b00, pcr[1:0])
		end
		$display("power down done");
		lfsr = nextRnd(lfsr);
		pulseLen = {4'h0, lfsr[3:0]} + 8'h03;
		pulseGo = 1'b1;
		step(1);
		pulseGo = 1'b0;
		step(30);
		`CHK("shortPulse", 1'b1, watchdogRun)
		@(negedge clk) clkGate = 1'b0;
		#600 clkGate = 1'b1;
		step(1);
		`CHK("standby", 2'b11, {watchdogRun, coreClkEn})
		flashProgReq = 1'b1;
		for (int s = 0; s < 2; s++) begin
			supplyValid = s[0];
			step(2);
			`CHK("flashAllow", s[0], flashProgAllow)
		end
		$display("pulse standby flash done");
		wrPwr(2'b01);
		initSeen = 1'b0;
		slip = 4'h0;
		pulseLen = 8'h28;
		pulseGo = 1'b1;
		step(1);
		pulseGo = 1'b0;
		for (int k = 0; k < 60 && coreReset !== 1'b1; k++) begin
			slip = slip + {3'h0, coreClkEn};
			step(1);
		end
		if (coreReset !== 1'b1) begin
			n_mismatch++;
			$display("[ERR] slip reset wait timeout");
			final_report;
		end
		`CHK("slip", 4'h2, slip)
		`CHK("rstPins", 5'h1f, {alWp, psWp, alOe, psOe, sfrReset})
		afterReset;
		`CHK("warmInit", 1'b0, initSeen)
		$display("warm reset done");
		// one clock under the minimum must be ignored, the minimum itself must reset from run
		for (int j = 0; j < 2; j++) begin
			pulseLen = 8'h17 + 8'(j);
			pulseGo = 1'b1;
			step(1);
			pulseGo = 1'b0;
			step(27);
			`CHK("edgePulse", (j == 0) ? 2'h1 : 2'h2, {coreReset, watchdogRun})
			afterReset;
		end
		`CHK("edgeInit", 1'b0, initSeen)
		$display("pulse edge done");
		final_report;
	end
endmodule // mcu_reset_and_power_modes_test
